/* verilog/rpc_pkg.sv */
// constants for the reference priority configuration bank
package rpc_pkg;

    // register addresses on the processor port
    localparam logic [7:0] RPC_ADDR_IN34 = 8'h19;
    localparam logic [7:0] RPC_ADDR_IN56 = 8'h1A;
    localparam logic [7:0] RPC_ADDR_SRC_SEL = 8'h4B;

    // field layout
    localparam int RPC_FIELD_W = 4;
    localparam int RPC_HI_LSB = 4;
    localparam int RPC_LO_LSB = 0;
    localparam int RPC_BANK_SEL_BIT = 4;
    localparam int RPC_NUM_IN = 4;
    localparam logic [3:0] RPC_FIRST_IN = 4'h3;
    localparam logic [3:0] RPC_PRIO_OFF = 4'h0;

    // reset values
    localparam logic [7:0] RPC_RST_IN34_MAIN = 8'h54;
    localparam logic [7:0] RPC_RST_IN34_AUX = 8'h00;
    localparam logic [7:0] RPC_RST_IN56_MAIN = 8'h76;
    localparam logic [7:0] RPC_RST_IN56_AUX = 8'h76;
    localparam logic [7:0] RPC_RST_SRC_SEL = 8'h00;

    // bank indices
    localparam int RPC_BANK_MAIN = 0;
    localparam int RPC_BANK_AUX = 1;

endpackage

/* verilog/rpc_ranker.sv */
// picks the highest-priority enabled input from a set of priority fields
`timescale 1ns/1ps
module rpc_ranker import rpc_pkg::*; #(
    parameter int NUM_IN = RPC_NUM_IN,
    parameter int FIELD_W = RPC_FIELD_W
) (
    // priority fields, input 0 in the low bits
    input wire logic [NUM_IN*FIELD_W-1:0] prio_i,
    // winner
    output logic [$clog2(NUM_IN)-1:0] best_idx_o,
    output logic best_vld_o
);

    logic [FIELD_W-1:0] best_prio;
    logic [FIELD_W-1:0] cur;

    always_comb begin
        best_prio = '1;
        best_idx_o = '0;
        best_vld_o = 1'b0;
        cur = '0;
        for (int i = 0; i < NUM_IN; i++) begin
            cur = prio_i[i*FIELD_W +: FIELD_W];
            // zero field takes the input out of the running
            if (cur != '0) begin
                // strict less-than: on a tie the lower input keeps the win
                if (!best_vld_o || cur < best_prio) begin
                    best_prio = cur;
                    best_idx_o = i[$clog2(NUM_IN)-1:0];
                    best_vld_o = 1'b1;
                end
            end
        end
    end

endmodule // rpc_ranker

/* verilog/rpc_bank.sv */
// reference priority register bank for inputs three to six, two path banks
//
// Function
// - in3/in4 holds input four in [7:4], three in [3:0], both read/write.
// - in5/in6 holds six in [7:4], five in [3:0], resets 0x76 in both banks.
// - a smaller nonzero priority value ranks higher than a larger one.
// - an input whose priority field is zero is excluded from selection.
// - with the path bank select bit at 0, accesses reach the main path copy.
// - with the path bank select bit at 1, accesses reach the aux path copy.
// - the in3/in4 register resets to 0x54 in the main bank, 0x00 in aux.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
module rpc_bank import rpc_pkg::*; #(
    parameter int NUM_IN = RPC_NUM_IN,
    parameter int FIELD_W = RPC_FIELD_W
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,

    // processor register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,

    // priority fields per bank, input three in the low nibble
    output logic [NUM_IN*FIELD_W-1:0] main_prio_o,
    output logic [NUM_IN*FIELD_W-1:0] aux_prio_o,

    // per input availability for automatic selection
    output logic [NUM_IN-1:0] main_avail_o,
    output logic [NUM_IN-1:0] aux_avail_o,

    // highest priority input per bank, as input number
    output logic [3:0] main_best_o,
    output logic main_best_vld_o,
    output logic [3:0] aux_best_o,
    output logic aux_best_vld_o,

    // current path bank select
    output logic path_bank_select_o
);

    localparam int IDX_W = $clog2(NUM_IN);

    // register state, indexed by bank
    logic [7:0] in34_ff [2];
    logic [7:0] in56_ff [2];
    logic [7:0] nxt_in34 [2];
    logic [7:0] nxt_in56 [2];
    logic path_bank_select_ff;
    logic nxt_path_bank_select;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;

    // ranking results
    logic [IDX_W-1:0] main_idx;
    logic main_vld;
    logic [IDX_W-1:0] aux_idx;
    logic aux_vld;
    logic [3:0] main_best_ff;
    logic [3:0] nxt_main_best;
    logic main_best_vld_ff;
    logic nxt_main_best_vld;
    logic [3:0] aux_best_ff;
    logic [3:0] nxt_aux_best;
    logic aux_best_vld_ff;
    logic nxt_aux_best_vld;

    logic bank;

    // read mux shared by the read path
    function automatic logic [7:0] read_word(
        input logic [7:0] a,
        input logic [7:0] r34,
        input logic [7:0] r56,
        input logic sel
    );
        logic [7:0] v;
        v = 8'h00;
        case (a)
            RPC_ADDR_IN34: v = r34;
            RPC_ADDR_IN56: v = r56;
            RPC_ADDR_SRC_SEL: v[RPC_BANK_SEL_BIT] = sel;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // pack both registers into one field vector, input three lowest
    function automatic logic [NUM_IN*FIELD_W-1:0] pack_fields(
        input logic [7:0] r34,
        input logic [7:0] r56
    );
        logic [NUM_IN*FIELD_W-1:0] v;
        v = '0;
        v[0*FIELD_W +: FIELD_W] = r34[RPC_LO_LSB +: FIELD_W];
        v[1*FIELD_W +: FIELD_W] = r34[RPC_HI_LSB +: FIELD_W];
        v[2*FIELD_W +: FIELD_W] = r56[RPC_LO_LSB +: FIELD_W];
        v[3*FIELD_W +: FIELD_W] = r56[RPC_HI_LSB +: FIELD_W];
        return v;
    endfunction

    // bank addressed by this cycle's access
    // a select write steers accesses from the next cycle on
    assign bank = path_bank_select_ff;

    // register file next state
    always_comb begin
        for (int b = 0; b < 2; b++) begin
            nxt_in34[b] = in34_ff[b];
            nxt_in56[b] = in56_ff[b];
        end
        nxt_path_bank_select = path_bank_select_ff;
        nxt_rdata = 8'h00;
        if (wr_i) begin
            case (addr_i)
                // only the addressed bank is touched
                RPC_ADDR_IN34: nxt_in34[bank] = wdata_i;
                RPC_ADDR_IN56: nxt_in56[bank] = wdata_i;
                RPC_ADDR_SRC_SEL: begin
                    nxt_path_bank_select = wdata_i[RPC_BANK_SEL_BIT];
                end
                default: begin
                end
            endcase
        end
        // read data valid only the cycle after the strobe
        if (rd_i) begin
            nxt_rdata = read_word(addr_i, in34_ff[bank], in56_ff[bank],
                path_bank_select_ff);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            in34_ff[RPC_BANK_MAIN] <= RPC_RST_IN34_MAIN;
            in34_ff[RPC_BANK_AUX] <= RPC_RST_IN34_AUX;
            in56_ff[RPC_BANK_MAIN] <= RPC_RST_IN56_MAIN;
            in56_ff[RPC_BANK_AUX] <= RPC_RST_IN56_AUX;
            path_bank_select_ff <= RPC_RST_SRC_SEL[RPC_BANK_SEL_BIT];
            rdata_ff <= 8'h00;
        end else begin
            for (int b = 0; b < 2; b++) begin
                in34_ff[b] <= nxt_in34[b];
                in56_ff[b] <= nxt_in56[b];
            end
            path_bank_select_ff <= nxt_path_bank_select;
            rdata_ff <= nxt_rdata;
        end
    end

    // field views
    assign main_prio_o = pack_fields(in34_ff[RPC_BANK_MAIN],
        in56_ff[RPC_BANK_MAIN]);
    assign aux_prio_o = pack_fields(in34_ff[RPC_BANK_AUX],
        in56_ff[RPC_BANK_AUX]);

    // availability stays combinational: no extra cycle of lag
    genvar gi;
    generate
        for (gi = 0; gi < NUM_IN; gi++) begin : g_avail
            assign main_avail_o[gi] =
                main_prio_o[gi*FIELD_W +: FIELD_W] != RPC_PRIO_OFF;
            assign aux_avail_o[gi] =
                aux_prio_o[gi*FIELD_W +: FIELD_W] != RPC_PRIO_OFF;
        end
    endgenerate

    // one ranker per path bank
    rpc_ranker #(
        .NUM_IN(NUM_IN),
        .FIELD_W(FIELD_W)
    ) u_rank_main (
        .prio_i(main_prio_o),
        .best_idx_o(main_idx),
        .best_vld_o(main_vld)
    );

    rpc_ranker #(
        .NUM_IN(NUM_IN),
        .FIELD_W(FIELD_W)
    ) u_rank_aux (
        .prio_i(aux_prio_o),
        .best_idx_o(aux_idx),
        .best_vld_o(aux_vld)
    );

    // winner registered: one cycle behind the fields, cuts the compare path
    always_comb begin
        nxt_main_best = main_vld ?
            RPC_FIRST_IN + 4'(main_idx) : 4'h0;
        nxt_main_best_vld = main_vld;
        nxt_aux_best = aux_vld ? RPC_FIRST_IN + 4'(aux_idx) : 4'h0;
        nxt_aux_best_vld = aux_vld;
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            main_best_ff <= 4'h0;
            main_best_vld_ff <= 1'b0;
            aux_best_ff <= 4'h0;
            aux_best_vld_ff <= 1'b0;
        end else begin
            main_best_ff <= nxt_main_best;
            main_best_vld_ff <= nxt_main_best_vld;
            aux_best_ff <= nxt_aux_best;
            aux_best_vld_ff <= nxt_aux_best_vld;
        end
    end

    // idle read data is zero, so a wired-or bus mux needs no gating
    assign rdata_o = rdata_ff;
    assign main_best_o = main_best_ff;
    assign main_best_vld_o = main_best_vld_ff;
    assign aux_best_o = aux_best_ff;
    assign aux_best_vld_o = aux_best_vld_ff;
    assign path_bank_select_o = path_bank_select_ff;

endmodule // rpc_bank

/* dv/rpc_bank_sva.sv */
// assertions on the ports of the reference priority bank
`timescale 1ns/1ps
module rpc_bank_sva import rpc_pkg::*; #(
    parameter int NUM_IN = RPC_NUM_IN,
    parameter int FIELD_W = RPC_FIELD_W
) (
    // clock, reset and register port
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    // bank state
    input wire logic [NUM_IN*FIELD_W-1:0] main_prio_o,
    input wire logic [NUM_IN*FIELD_W-1:0] aux_prio_o,
    input wire logic [NUM_IN-1:0] main_avail_o,
    input wire logic [NUM_IN-1:0] aux_avail_o,
    input wire logic [3:0] main_best_o,
    input wire logic main_best_vld_o,
    input wire logic path_bank_select_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // strict less-than keeps the lower input number on a tie
    function automatic logic [4:0] pick(logic [NUM_IN*FIELD_W-1:0] p);
        logic [4:0] r;
        logic [3:0] b;
        r = 5'h00;
        b = 4'hF;
        for (int i = 0; i < NUM_IN; i++) begin
            if (p[i*4 +: 4] != 4'h0 && (!r[4] || p[i*4 +: 4] < b)) begin
                b = p[i*4 +: 4];
                r = {1'b1, RPC_FIRST_IN + 4'(i)};
            end
        end
        return r;
    endfunction
    function automatic logic [NUM_IN-1:0] nz(logic [NUM_IN*FIELD_W-1:0] p);
        for (int i = 0; i < NUM_IN; i++) nz[i] = p[i*4 +: 4] != 4'h0;
    endfunction
    sequence s_rd(logic [7:0] a, logic s);
        rd_i && addr_i == a && path_bank_select_o == s;
    endsequence
    sequence s_wr(logic [7:0] a, logic s);
        wr_i && addr_i == a && path_bank_select_o == s;
    endsequence
    a_read_main: assert property (
        s_rd(RPC_ADDR_IN34, 1'b0) |=> rdata_o == $past(main_prio_o[7:0]))
        else $error("main read mismatch");
    a_read_aux: assert property (
        s_rd(RPC_ADDR_IN34, 1'b1) |=> rdata_o == $past(aux_prio_o[7:0]))
        else $error("aux read mismatch");
    a_read_pair56: assert property (
        s_rd(RPC_ADDR_IN56, 1'b0) |=> rdata_o == $past(main_prio_o[15:8]))
        else $error("in5/in6 read mismatch");
    a_read_idle_zero: assert property (
        !$past(rd_i) |-> rdata_o == 8'h00) else $error("rdata not idle");
    a_write_main_only: assert property (
        s_wr(RPC_ADDR_IN34, 1'b0) |=>
        main_prio_o[7:0] == $past(wdata_i) && $stable(aux_prio_o))
        else $error("main write wrong");
    a_write_aux_only: assert property (
        s_wr(RPC_ADDR_IN56, 1'b1) |=>
        aux_prio_o[15:8] == $past(wdata_i) && $stable(main_prio_o))
        else $error("aux write wrong");
    a_best_rank: assert property (
        $past(resetn_i) |->
        {main_best_vld_o, main_best_o} == pick($past(main_prio_o)))
        else $error("ranking wrong");
    a_reset_values: assert property (disable iff (1'b0)
        !resetn_i |=> main_prio_o == 16'h7654 && aux_prio_o == 16'h7600)
        else $error("reset values wrong");
    a_select_write: assert property (
        wr_i && addr_i == RPC_ADDR_SRC_SEL |=>
        path_bank_select_o == $past(wdata_i[4])) else $error("select wrong");
    a_avail_flags: assert property (
        main_avail_o == nz(main_prio_o) && aux_avail_o == nz(aux_prio_o))
        else $error("availability wrong");
endmodule // rpc_bank_sva

bind rpc_bank rpc_bank_sva #(.NUM_IN(NUM_IN), .FIELD_W(FIELD_W)) u_sva (
    .clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .main_prio_o(main_prio_o), .aux_prio_o(aux_prio_o),
    .main_avail_o(main_avail_o), .aux_avail_o(aux_avail_o),
    .main_best_o(main_best_o), .main_best_vld_o(main_best_vld_o),
    .path_bank_select_o(path_bank_select_o));

/* dv/test_rpc_bank.sv */
// self-checking bench for the reference priority bank
`timescale 1ns/1ps
module test_rpc_bank import rpc_pkg::*; ;
    logic clk_i = 0, resetn_i = 0, wr_i = 0, rd_i = 0, mv, av;
    logic [7:0] addr_i = 0, wdata_i = 0, rdata_o;
    logic [3:0] mb, ab;
    int bad_count = 0, n_compared = 0;
    // {write data, 3'h0, expected valid and best input}
    logic [15:0] tbl [5] = '{16'h3215, 16'h2316, 16'h2215, 16'hF016, 16'h0};
    always #2 clk_i = ~clk_i;
    rpc_bank u_rpc_bank (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .main_prio_o(), .aux_prio_o(), .main_avail_o(), .aux_avail_o(),
        .main_best_o(mb), .main_best_vld_o(mv), .aux_best_o(ab),
        .aux_best_vld_o(av), .path_bank_select_o());
    task cmp(string n, logic [7:0] e, logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task rd(logic [7:0] a, logic [7:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 cmp("rdata", e, rdata_o);
    endtask
    // best outputs lag the fields by one cycle
    task best(logic [4:0] m, logic [4:0] x);
        repeat (2) @(posedge clk_i);
        #1 cmp("main_best", {3'h0, m}, {3'h0, mv, mb});
        cmp("aux_best", {3'h0, x}, {3'h0, av, ab});
    endtask
    task final_report;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk_i);
        resetn_i <= 1'b1;
        rd(RPC_ADDR_IN34, 8'h54);
        rd(RPC_ADDR_IN56, 8'h76);
        best(5'h13, 5'h15);
        wr(RPC_ADDR_SRC_SEL, 8'h10);
        rd(RPC_ADDR_SRC_SEL, 8'h10);
        rd(RPC_ADDR_IN34, 8'h00);
        rd(RPC_ADDR_IN56, 8'h76);
        wr(RPC_ADDR_IN34, 8'hA1);
        rd(RPC_ADDR_IN34, 8'hA1);
        wr(RPC_ADDR_IN56, 8'h21);
        rd(RPC_ADDR_IN56, 8'h21);
        best(5'h13, 5'h13);
        wr(RPC_ADDR_SRC_SEL, 8'h00);
        rd(RPC_ADDR_IN34, 8'h54);
        wr(RPC_ADDR_IN34, 8'h00);
        foreach (tbl[i]) begin
            wr(RPC_ADDR_IN56, tbl[i][15:8]);
            best(tbl[i][4:0], 5'h13);
        end
        wr(8'h20, 8'hFF);
        rd(8'h20, 8'h00);
        rd(RPC_ADDR_IN34, 8'h00);
        final_report();
    end
    // tests need well under 300 cycles
    initial begin
        repeat (2000) @(posedge clk_i);
        bad_count++;
        final_report();
    end
endmodule // test_rpc_bank
